// >>> hw/eecl_pkg.sv
// constants, field layout and state codes of the configuration preload loader
//
// Contract
// RULE1: word 02h fills vendor id, ports 0-3
// RULE2: word 04h fills device id, ports 0-3
// RULE3: word 06h bits 3:1 give L0s exit latency
// RULE4: word 06h bits 6:4 give L1 exit latency
// RULE5: word 06h bits 8,9 set ordering modes
// RULE6: word 06h bit 10 selects store-and-forward
// RULE7: word 06h bits 12:11 give cut-through threshold
// RULE8: word 06h bits 13,14 set arbitration, credit modes
// RULE9: word 06h bit 15 requests INTA, ports 1-2
// RULE10: word 0Ch bit 0 sets max payload support
// RULE11: word 0Ch bits 2:1 give ASPM support level
// RULE12: word 0Ch bit 3 flags role-based error reporting
// RULE13: word 0Ch bits 4,5 disable MSI and AER
// RULE14: word 0Ch bit 6 disables compliance parity control
// RULE15: word 0Ch bit 7 disables power management
// RULE16: word 0Ch bit 10 freezes ordering feature
// RULE17: word 0Ch bit 11 sets transmit start latency
// RULE18: word 0Ch bit 12 enables surprise-down, ports 1-3
// RULE19: word 0Ch bits 15:13 fill B8h bits 15:13
// RULE20: word 0Eh low byte is revision id
// RULE21: word 10h low byte: port 0 training count
// RULE22: word 10h bits 9:8: port 0 clock offset
// RULE23: bad signature loads nothing, defaults stay
// RULE24: load ascending after reset before host access
package eecl_pkg;

	// ********************************************************
	// eeprom word addresses
	// ********************************************************
	localparam int          EE_AW        = 8;
	localparam int          EE_DW        = 16;
	localparam logic [7:0]  EE_SIG_ADDR  = 8'h00;
	localparam logic [7:0]  EE_VID_ADDR  = 8'h02;
	localparam logic [7:0]  EE_DID_ADDR  = 8'h04;
	localparam logic [7:0]  EE_MODE_ADDR = 8'h06;
	localparam logic [7:0]  EE_CAPS_ADDR = 8'h0C;
	localparam logic [7:0]  EE_REV_ADDR  = 8'h0E;
	localparam logic [7:0]  EE_P0_ADDR   = 8'h10;
	localparam logic [7:0]  EE_LAST_ADDR = 8'h10;
	localparam logic [7:0]  EE_STEP      = 8'h02;

	// ********************************************************
	// configuration dword offsets within one port
	// ********************************************************
	localparam logic [7:0]  CFG_ID      = 8'h00;
	localparam logic [7:0]  CFG_REV     = 8'h08;
	localparam logic [7:0]  CFG_INTPIN  = 8'h3C;
	localparam logic [7:0]  CFG_PMCAP   = 8'hA8;
	localparam logic [7:0]  CFG_CAPDIS  = 8'hB0;
	localparam logic [7:0]  CFG_SWMODE  = 8'hB4;
	localparam logic [7:0]  CFG_PHYCTL  = 8'hB8;
	localparam logic [7:0]  CFG_DEVCAP  = 8'hE4;
	localparam logic [7:0]  CFG_LINKCAP = 8'hEC;

	// ********************************************************
	// source bits in the eeprom words
	// ********************************************************
	localparam int S06_L0S_LO = 1;
	localparam int S06_L0S_HI = 3;
	localparam int S06_L1_LO  = 4;
	localparam int S06_L1_HI  = 6;
	localparam int S06_ORD_EG = 8;
	localparam int S06_ORD_TG = 9;
	localparam int S06_SAF    = 10;
	localparam int S06_CT_LO  = 11;
	localparam int S06_CT_HI  = 12;
	localparam int S06_ARB    = 13;
	localparam int S06_CRD    = 14;
	localparam int S06_INTA   = 15;
	localparam int S0C_MPS    = 0;
	localparam int S0C_ASPM_LO = 1;
	localparam int S0C_ASPM_HI = 2;
	localparam int S0C_RBER   = 3;
	localparam int S0C_MSI    = 4;
	localparam int S0C_AER    = 5;
	localparam int S0C_CPPC   = 6;
	localparam int S0C_PM     = 7;
	localparam int S0C_FRZ    = 10;
	localparam int S0C_TXSOF  = 11;
	localparam int S0C_SDN    = 12;
	localparam int S0C_DSEL   = 13;
	localparam int S0C_FCU    = 14;
	localparam int S0C_4KB    = 15;
	localparam int S0E_REV_HI = 7;
	localparam int S10_FTC_HI = 7;
	localparam int S10_PPM_LO = 8;
	localparam int S10_PPM_HI = 9;

	// ********************************************************
	// destination bits in the configuration dwords
	// ********************************************************
	localparam int D_VID_HI   = 15;
	localparam int D_DID_LO   = 16;
	localparam int D_DID_HI   = 31;
	localparam int D_REV_HI   = 7;
	localparam int D_INTA     = 8;
	localparam int D_PPM_LO   = 13;
	localparam int D_PPM_HI   = 14;
	localparam int D_PMDIS    = 13;
	localparam int D_MSIDIS   = 14;
	localparam int D_AERDIS   = 15;
	localparam int D_SAF      = 0;
	localparam int D_CT_LO    = 1;
	localparam int D_CT_HI    = 2;
	localparam int D_ARB      = 3;
	localparam int D_CRD      = 4;
	localparam int D_ORD_EG   = 5;
	localparam int D_ORD_TG   = 6;
	localparam int D_FRZ      = 7;
	localparam int D_CPPC     = 15;
	localparam int D_FTC_HI   = 7;
	localparam int D_TXSOF    = 12;
	localparam int D_DSEL     = 13;
	localparam int D_FCU      = 14;
	localparam int D_4KB      = 15;
	localparam int D_MPS      = 0;
	localparam int D_RBER     = 15;
	localparam int D_ASPM_LO  = 10;
	localparam int D_ASPM_HI  = 11;
	localparam int D_L0S_LO   = 12;
	localparam int D_L0S_HI   = 14;
	localparam int D_L1_LO    = 15;
	localparam int D_L1_HI    = 17;
	localparam int D_SDN      = 19;

	// ********************************************************
	// port groups
	// ********************************************************
	localparam logic [1:0] PORT_FIRST_DN = 2'd1;
	localparam logic [1:0] PORT_LAST_SW  = 2'd2;
	localparam logic [1:0] PORT_UP       = 2'd0;

	// ********************************************************
	// bus map: port in address bits 9:8, dword offset below
	// ********************************************************
	localparam int          AXI_AW      = 12;
	localparam int          PORT_LSB    = 8;
	localparam int          PORT_MSB    = 9;
	localparam int          CFG_MSB     = 7;
	localparam logic [11:0] CTRL_ADDR   = 12'h400;
	localparam logic [11:0] STAT_ADDR   = 12'h404;
	localparam logic [11:0] CFG_END     = 12'h400;
	localparam int          CTRL_RELOAD = 0;
	localparam int          STAT_DONE   = 0;
	localparam int          STAT_SIGOK  = 1;
	localparam int          STAT_BUSY   = 2;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ********************************************************
	// loader states
	// ********************************************************
	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_WAIT  = 3'b010,
		ST_DONE  = 3'b100
	} eecl_state_t;

endpackage : eecl_pkg

// >>> hw/eecl_loader.sv
// eeprom configuration preload loader with an axi4-lite view of the loaded fields
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module eecl_loader #(
	parameter logic [15:0] SIGNATURE   = 16'hA5C3, // arbitrary value
	parameter logic [15:0] DEF_VENDOR  = 16'h0F0F, // arbitrary value
	parameter logic [15:0] DEF_DEVICE  = 16'h0101, // arbitrary value
	parameter logic [15:0] DEF_MODE    = 16'h0000, // word 06h default
	parameter logic [15:0] DEF_CAPS    = 16'h0000, // word 0Ch default
	parameter logic [15:0] DEF_REV     = 16'h0000, // word 0Eh default
	parameter logic [15:0] DEF_P0      = 16'h0000  // word 10h default
) (
	input  wire  logic        CLK,           // 250 MHz clock
	input  wire  logic        RESET,         // synchronous, active high
	// eeprom word port
	output var   logic        EE_REQ,        // one-cycle word read request
	output var   logic [7:0]  EE_ADDR,       // byte address of requested word
	input  wire  logic [15:0] EE_DATA,       // returned word
	input  wire  logic        EE_VALID,      // word valid pulse
	// status
	output var   logic        LOAD_DONE,     // load finished
	output var   logic        SIG_OK,        // signature matched
	// axi4-lite slave
	input  wire  logic [11:0] S_AXI_AWADDR,  // write address
	input  wire  logic        S_AXI_AWVALID, // write address valid
	output var   logic        S_AXI_AWREADY, // write address ready
	input  wire  logic [31:0] S_AXI_WDATA,   // write data
	input  wire  logic [3:0]  S_AXI_WSTRB,   // write strobes
	input  wire  logic        S_AXI_WVALID,  // write data valid
	output var   logic        S_AXI_WREADY,  // write data ready
	output var   logic [1:0]  S_AXI_BRESP,   // write response
	output var   logic        S_AXI_BVALID,  // write response valid
	input  wire  logic        S_AXI_BREADY,  // write response ready
	input  wire  logic [11:0] S_AXI_ARADDR,  // read address
	input  wire  logic        S_AXI_ARVALID, // read address valid
	output var   logic        S_AXI_ARREADY, // read address ready
	output var   logic [31:0] S_AXI_RDATA,   // read data
	output var   logic [1:0]  S_AXI_RRESP,   // read response
	output var   logic        S_AXI_RVALID,  // read data valid
	input  wire  logic        S_AXI_RREADY   // read data ready
);

	// ********************************************************
	// configuration dword assembly
	// ********************************************************
	// build one dword of one port from the loaded words
	function automatic logic [31:0] cfg_dword(
		input logic [1:0]  port,
		input logic [7:0]  off,
		input logic [15:0] vid,
		input logic [15:0] did,
		input logic [15:0] w06,
		input logic [15:0] w0c,
		input logic [15:0] w0e,
		input logic [15:0] w10
	);
		logic [31:0] d;
		logic        sw;
		logic        dn;
		logic        up;
		d  = 32'h0000_0000;
		sw = (port <= eecl_pkg::PORT_LAST_SW);
		dn = (port >= eecl_pkg::PORT_FIRST_DN);
		up = (port == eecl_pkg::PORT_UP);
		unique case (off)
			eecl_pkg::CFG_ID: begin
				d[eecl_pkg::D_VID_HI:0] = vid; // RULE1
				d[eecl_pkg::D_DID_HI:eecl_pkg::D_DID_LO] = did; // RULE2
			end
			eecl_pkg::CFG_REV: begin
				d[eecl_pkg::D_REV_HI:0] = w0e[eecl_pkg::S0E_REV_HI:0]; // RULE20
			end
			eecl_pkg::CFG_INTPIN: begin
				d[eecl_pkg::D_INTA] = sw && dn && w06[eecl_pkg::S06_INTA]; // RULE9
			end
			eecl_pkg::CFG_PMCAP: begin
				if (up) begin
					d[eecl_pkg::D_PPM_HI:eecl_pkg::D_PPM_LO] =
						w10[eecl_pkg::S10_PPM_HI:eecl_pkg::S10_PPM_LO]; // RULE22
				end
			end
			eecl_pkg::CFG_CAPDIS: begin
				d[eecl_pkg::D_MSIDIS] = w0c[eecl_pkg::S0C_MSI]; // RULE13
				d[eecl_pkg::D_AERDIS] = w0c[eecl_pkg::S0C_AER]; // RULE13
				d[eecl_pkg::D_PMDIS]  = w0c[eecl_pkg::S0C_PM]; // RULE15
			end
			eecl_pkg::CFG_SWMODE: begin
				if (sw) begin
					d[eecl_pkg::D_ORD_EG] = w06[eecl_pkg::S06_ORD_EG]; // RULE5
					d[eecl_pkg::D_ORD_TG] = w06[eecl_pkg::S06_ORD_TG]; // RULE5
					d[eecl_pkg::D_SAF]    = w06[eecl_pkg::S06_SAF]; // RULE6
					d[eecl_pkg::D_CT_HI:eecl_pkg::D_CT_LO] =
						w06[eecl_pkg::S06_CT_HI:eecl_pkg::S06_CT_LO]; // RULE7
					d[eecl_pkg::D_ARB]    = w06[eecl_pkg::S06_ARB]; // RULE8
					d[eecl_pkg::D_CRD]    = w06[eecl_pkg::S06_CRD]; // RULE8
				end
				d[eecl_pkg::D_CPPC] = w0c[eecl_pkg::S0C_CPPC]; // RULE14
				d[eecl_pkg::D_FRZ]  = w0c[eecl_pkg::S0C_FRZ]; // RULE16
			end
			eecl_pkg::CFG_PHYCTL: begin
				if (up) begin
					d[eecl_pkg::D_FTC_HI:0] = w10[eecl_pkg::S10_FTC_HI:0]; // RULE21
				end
				d[eecl_pkg::D_TXSOF] = w0c[eecl_pkg::S0C_TXSOF]; // RULE17
				d[eecl_pkg::D_DSEL]  = w0c[eecl_pkg::S0C_DSEL]; // RULE19
				d[eecl_pkg::D_FCU]   = w0c[eecl_pkg::S0C_FCU]; // RULE19
				d[eecl_pkg::D_4KB]   = w0c[eecl_pkg::S0C_4KB]; // RULE19
			end
			eecl_pkg::CFG_DEVCAP: begin
				d[eecl_pkg::D_MPS]  = w0c[eecl_pkg::S0C_MPS]; // RULE10
				d[eecl_pkg::D_RBER] = w0c[eecl_pkg::S0C_RBER]; // RULE12
			end
			eecl_pkg::CFG_LINKCAP: begin
				d[eecl_pkg::D_L0S_HI:eecl_pkg::D_L0S_LO] =
					w06[eecl_pkg::S06_L0S_HI:eecl_pkg::S06_L0S_LO]; // RULE3
				d[eecl_pkg::D_L1_HI:eecl_pkg::D_L1_LO] =
					w06[eecl_pkg::S06_L1_HI:eecl_pkg::S06_L1_LO]; // RULE4
				d[eecl_pkg::D_ASPM_HI:eecl_pkg::D_ASPM_LO] =
					w0c[eecl_pkg::S0C_ASPM_HI:eecl_pkg::S0C_ASPM_LO]; // RULE11
				d[eecl_pkg::D_SDN] = dn && w0c[eecl_pkg::S0C_SDN]; // RULE18
			end
			default: begin
				d = 32'h0000_0000; // reserved dwords read as zero
			end
		endcase
		return d;
	endfunction : cfg_dword

	// ********************************************************
	// state
	// ********************************************************
	eecl_pkg::eecl_state_t state;
	logic [15:0]           w_vid;
	logic [15:0]           w_did;
	logic [15:0]           w_mode;
	logic [15:0]           w_caps;
	logic [15:0]           w_rev;
	logic [15:0]           w_p0;
	logic [11:0]           aw_addr;
	logic                  aw_held;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  w_held;

	// ********************************************************
	// loader decode
	// ********************************************************
	// a word only lands once the signature has passed, so a bad image leaves defaults
	wire        got_word   = (state == eecl_pkg::ST_WAIT) && EE_VALID;
	wire        at_sig     = (EE_ADDR == eecl_pkg::EE_SIG_ADDR);
	wire        sig_bad    = got_word && at_sig && (EE_DATA != SIGNATURE); // RULE23
	wire        take_word  = got_word && !at_sig; // RULE23
	wire        last_word  = (EE_ADDR == eecl_pkg::EE_LAST_ADDR);
	wire [7:0]  next_addr  = EE_ADDR + eecl_pkg::EE_STEP; // RULE24

	// ********************************************************
	// bus decode
	// ********************************************************
	wire        aw_take    = S_AXI_AWVALID && S_AXI_AWREADY;
	wire        w_take     = S_AXI_WVALID && S_AXI_WREADY;
	wire        wr_fire    = aw_held && w_held && !S_AXI_BVALID;
	wire        wr_ctrl    = (aw_addr == eecl_pkg::CTRL_ADDR);
	wire        wr_mapped  = wr_ctrl || (aw_addr == eecl_pkg::STAT_ADDR) ||
	                         (aw_addr < eecl_pkg::CFG_END);
	wire        reload_go  = wr_fire && wr_ctrl && w_strb[0] &&
	                         w_data[eecl_pkg::CTRL_RELOAD];
	wire        ar_take    = S_AXI_ARVALID && S_AXI_ARREADY;
	wire        b_done     = S_AXI_BVALID && S_AXI_BREADY;
	wire        r_done     = S_AXI_RVALID && S_AXI_RREADY;
	wire        loaded     = (state == eecl_pkg::ST_DONE);
	wire        rd_cfg     = (S_AXI_ARADDR < eecl_pkg::CFG_END);
	wire        rd_ctrl    = (S_AXI_ARADDR == eecl_pkg::CTRL_ADDR);
	wire        rd_stat    = (S_AXI_ARADDR == eecl_pkg::STAT_ADDR);
	wire [1:0]  rd_port    = S_AXI_ARADDR[eecl_pkg::PORT_MSB:eecl_pkg::PORT_LSB];
	wire [7:0]  rd_off     = {S_AXI_ARADDR[eecl_pkg::CFG_MSB:2], 2'b00};
	wire [31:0] stat_word  = {29'h0000_0000, !loaded, SIG_OK, LOAD_DONE};
	wire [31:0] cfg_word   = cfg_dword(rd_port, rd_off, w_vid, w_did,
	                                   w_mode, w_caps, w_rev, w_p0);
	wire [31:0] next_rdata = rd_cfg  ? cfg_word :
	                         rd_stat ? stat_word : 32'h0000_0000;
	wire [1:0]  next_rresp = (rd_cfg || rd_ctrl || rd_stat) ?
	                         eecl_pkg::RESP_OKAY : eecl_pkg::RESP_SLVERR;
	// host requests are held off while the image is loading
	wire        next_arready = loaded && !reload_go && !S_AXI_RVALID && !ar_take; // RULE24
	wire        next_awready = loaded && !reload_go && !aw_held && !aw_take; // RULE24
	wire        next_wready  = loaded && !reload_go && !w_held && !w_take; // RULE24

	// ********************************************************
	// loader sequencer: ascending word fetch after reset or reload
	// ********************************************************
	always_ff @(posedge CLK) begin
		if (RESET || reload_go) begin
			state     <= eecl_pkg::ST_FETCH; // RULE24
			EE_ADDR   <= eecl_pkg::EE_SIG_ADDR;
			EE_REQ    <= 1'b0;
			LOAD_DONE <= 1'b0;
			SIG_OK    <= 1'b0;
		end else begin
			EE_REQ <= 1'b0;
			unique case (state)
				eecl_pkg::ST_FETCH: begin
					EE_REQ <= 1'b1;
					state  <= eecl_pkg::ST_WAIT;
				end
				eecl_pkg::ST_WAIT: begin
					if (sig_bad) begin
						state     <= eecl_pkg::ST_DONE; // RULE23
						LOAD_DONE <= 1'b1;
					end else if (got_word) begin
						SIG_OK <= 1'b1;
						if (last_word) begin
							state     <= eecl_pkg::ST_DONE;
							LOAD_DONE <= 1'b1;
						end else begin
							EE_ADDR <= next_addr; // RULE24
							state   <= eecl_pkg::ST_FETCH;
						end
					end
				end
				eecl_pkg::ST_DONE: begin
					state <= eecl_pkg::ST_DONE;
				end
				default: begin
					state <= eecl_pkg::ST_FETCH;
				end
			endcase
		end
	end

	// ********************************************************
	// loaded words; defaults come back on every reload
	// ********************************************************
	always_ff @(posedge CLK) begin
		if (RESET || reload_go) begin
			w_vid  <= DEF_VENDOR;
			w_did  <= DEF_DEVICE;
			w_mode <= DEF_MODE;
			w_caps <= DEF_CAPS;
			w_rev  <= DEF_REV;
			w_p0   <= DEF_P0;
		end else if (take_word) begin
			if (EE_ADDR == eecl_pkg::EE_VID_ADDR)  w_vid  <= EE_DATA; // RULE1
			if (EE_ADDR == eecl_pkg::EE_DID_ADDR)  w_did  <= EE_DATA; // RULE2
			if (EE_ADDR == eecl_pkg::EE_MODE_ADDR) w_mode <= EE_DATA; // RULE5
			if (EE_ADDR == eecl_pkg::EE_CAPS_ADDR) w_caps <= EE_DATA; // RULE13
			if (EE_ADDR == eecl_pkg::EE_REV_ADDR)  w_rev  <= EE_DATA; // RULE20
			if (EE_ADDR == eecl_pkg::EE_P0_ADDR)   w_p0   <= EE_DATA; // RULE21
		end
	end

	// ********************************************************
	// axi write channels: address and data taken in either order
	// ********************************************************
	always_ff @(posedge CLK) begin
		if (RESET) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
		end else begin
			S_AXI_AWREADY <= next_awready && !wr_fire;
			S_AXI_WREADY  <= next_wready && !wr_fire;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// ********************************************************
	// axi write response; configuration dwords are read-only
	// ********************************************************
	always_ff @(posedge CLK) begin
		if (RESET) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= eecl_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= wr_mapped ? eecl_pkg::RESP_OKAY : eecl_pkg::RESP_SLVERR;
		end else if (b_done) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ********************************************************
	// axi read channel: one read in flight
	// ********************************************************
	always_ff @(posedge CLK) begin
		if (RESET) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= eecl_pkg::RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= next_arready;
			if (ar_take) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= next_rdata;
				S_AXI_RRESP  <= next_rresp;
			end else if (r_done) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule : eecl_loader

`default_nettype wire

// >>> verification/eecl_properties.sv
// port assertions of the configuration preload loader
`timescale 1ns/100ps
`default_nettype none

module eecl_properties (
	input wire logic        CLK,           // clock
	input wire logic        RESET,         // reset
	input wire logic        EE_REQ,        // word request
	input wire logic [7:0]  EE_ADDR,       // word address
	input wire logic        EE_VALID,      // word valid
	input wire logic        LOAD_DONE,     // load over
	input wire logic        SIG_OK,        // signature good
	input wire logic [11:0] S_AXI_ARADDR,  // read address
	input wire logic        S_AXI_ARVALID, // read valid
	input wire logic        S_AXI_ARREADY, // read ready
	input wire logic        S_AXI_AWREADY, // write ready
	input wire logic        S_AXI_RVALID,  // data valid
	input wire logic [1:0]  S_AXI_RRESP    // read response
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// ***********************************************
	// fetch order, host lock-out and read answers
	// ***********************************************
	// words climb two bytes at a time from zero; a restart begins again at zero
	a_addr_ascend: assert property (EE_REQ |-> EE_ADDR == 8'h00 ||
		EE_ADDR == $past(EE_ADDR, 2) + 8'h02) else $error("word address out of order");
	a_addr_range: assert property (EE_REQ |-> EE_ADDR <= 8'h10 && !EE_ADDR[0])
		else $error("word address beyond last word");
	a_word_answer: assert property (EE_VALID && !LOAD_DONE |-> ##2 (EE_REQ || LOAD_DONE))
		else $error("no follow-up after a word");
	a_done_bound: assert property ($fell(RESET) |-> ##[1:200] LOAD_DONE)
		else $error("load never finished");
	a_full_walk: assert property ($rose(LOAD_DONE) && SIG_OK |-> EE_ADDR == 8'h10)
		else $error("good load ended early");
	// one cycle of grace: the readies may fall on the edge that restarts a load
	a_hold_host: assert property (!LOAD_DONE ##1 !LOAD_DONE |->
		!S_AXI_ARREADY && !S_AXI_AWREADY) else $error("host taken while loading");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR[11:2] > 10'h101 |=> S_AXI_RRESP == eecl_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : eecl_properties
`default_nettype wire

// >>> verification/eecl_ee_model.sv
// word-at-a-time model of the configuration eeprom
`timescale 1ns/100ps
`default_nettype none

module eecl_ee_model (
	input  wire logic        clk,     // loader clock
	input  wire logic        slow,    // answer after three idle cycles
	input  wire logic        ee_req,  // word request
	input  wire logic [7:0]  ee_addr, // word byte address
	output var  logic [15:0] ee_data, // word, toggles when not valid
	output var  logic        ee_vld   // word valid pulse
);
	logic [15:0] mem [9];
	logic [7:0]  addr;
	logic [1:0]  cnt  = 2'h0;
	logic        busy = 1'b0;

	initial ee_vld = 1'b0;
	initial ee_data = 16'h0000;
	// one answer per request; the bus shows garbage so a stale sample cannot pass
	always @(posedge clk) begin
		ee_vld <= 1'b0;
		ee_data <= ~ee_data;
		if (ee_req) begin
			busy <= 1'b1;
			addr <= ee_addr;
			cnt <= slow ? 2'h3 : 2'h0;
		end else if (cnt != 2'h0)
			cnt <= cnt - 2'h1;
		else if (busy) begin
			busy <= 1'b0;
			ee_vld <= 1'b1;
			ee_data <= mem[addr[4:1]];
		end
	end
endmodule : eecl_ee_model
`default_nettype wire

// >>> verification/eeprom_config_preload_map_test.sv
// self-checking bench of the configuration preload loader
`timescale 1ns/100ps
`default_nettype none

module eeprom_config_preload_map_test;
	localparam logic [15:0] SIG  = 16'h3C5A; // arbitrary value
	localparam logic [15:0] DVID = 16'h1234; // arbitrary value
	localparam logic [15:0] DDID = 16'h5678; // arbitrary value
	localparam logic [7:0]  OFFS [10] = '{8'h00, 8'h08, 8'h3C, 8'hA8, 8'hB0,
		8'hB4, 8'hB8, 8'hE4, 8'hEC, 8'h10};
	logic        clk, ee_req, ee_vld, done, sig, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, good;
	logic        reset = 1'b1, slow = 1'b0, aw_vld = 1'b0, w_vld = 1'b0, ar_vld = 1'b0;
	logic [1:0]  b_resp, r_resp, rs;
	logic [7:0]  ee_addr;
	logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
	logic [15:0] ee_data, w [9], lf = 16'h0026;
	logic [31:0] r_data, d, w_data = 32'h0000_0000;
	int          failures = 0, cmp_count = 0;

	eecl_loader #(.SIGNATURE(SIG), .DEF_VENDOR(DVID), .DEF_DEVICE(DDID)) dut_u (
		.CLK(clk), .RESET(reset), .EE_REQ(ee_req), .EE_ADDR(ee_addr), .EE_DATA(ee_data),
		.EE_VALID(ee_vld), .LOAD_DONE(done), .SIG_OK(sig), .S_AXI_AWADDR(aw_addr),
		.S_AXI_AWVALID(aw_vld), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_data),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_vld), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp),
		.S_AXI_BVALID(b_vld), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar_addr),
		.S_AXI_ARVALID(ar_vld), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data),
		.S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld), .S_AXI_RREADY(1'b1));
	eecl_ee_model ee_u (.clk(clk), .slow(slow), .ee_req(ee_req), .ee_addr(ee_addr),
		.ee_data(ee_data), .ee_vld(ee_vld));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ***********************************************
	// helpers
	// ***********************************************
	function automatic logic [15:0] lfsr();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : lfsr

	// field image of one port after a load; a bad signature leaves defaults
	function automatic logic [31:0] exp_cfg(input int p, input logic [7:0] off);
		logic [15:0] m, c, f;
		logic [31:0] x;
		m = good ? w[3] : 16'h0000;
		c = good ? w[6] : 16'h0000;
		f = good ? w[8] : 16'h0000;
		x = 32'h0000_0000;
		case (off)
			8'h00: x = good ? {w[2], w[1]} : {DDID, DVID};
			8'h08: x[7:0] = good ? w[7][7:0] : 8'h00;
			8'h3C: x[8] = m[15] && (p == 1 || p == 2);
			8'hA8: x[14:13] = (p == 0) ? f[9:8] : 2'h0;
			8'hB0: x[15:13] = {c[5], c[4], c[7]};
			8'hB4: begin
				x[15:7] = {c[6], 7'h00, c[10]};
				x[6:0] = (p < 3) ? {m[9:8], m[14:13], m[12:10]} : 7'h00;
			end
			8'hB8: x[15:0] = {c[15:13], c[11], 4'h0, (p == 0) ? f[7:0] : 8'h00};
			8'hE4: x[15:0] = {c[3], 14'h0000, c[0]};
			8'hEC: x[19:10] = {c[12] && p > 0, 1'b0, m[6:1], c[2:1]};
			default: x = 32'h0000_0000;
		endcase
		return x;
	endfunction : exp_cfg

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// the read ready stays high, so a read ends at the edge that shows valid data
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] r);
		ar_addr <= a;
		ar_vld <= 1'b1;
		@(posedge clk);
		while (!ar_rdy) @(posedge clk);
		ar_vld <= 1'b0;
		@(posedge clk);
		while (!r_vld) @(posedge clk);
		dat = r_data;
		r = r_resp;
	endtask : axi_rd

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		aw_addr <= a;
		w_data <= dat;
		aw_vld <= 1'b1;
		w_vld <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (aw_rdy && !aw_done) aw_vld <= 1'b0;
			if (w_rdy && !w_done) w_vld <= 1'b0;
			aw_done = aw_done || aw_rdy;
			w_done = w_done || w_rdy;
		end
		@(posedge clk);
		while (!b_vld) @(posedge clk);
		r = b_resp;
	endtask : axi_wr

	// random words, with the two-bit codes stepped through every value
	task automatic fill(input int rnd);
		good = (rnd != 4);
		for (int i = 0; i < 9; i++)
			w[i] = lfsr();
		w[0] = good ? SIG : ~SIG;
		w[3][12:11] = rnd[1:0];
		w[6][2:1] = rnd[1:0];
		w[8][9:8] = rnd[1:0];
		for (int i = 0; i < 9; i++)
			ee_u.mem[i] = w[i];
	endtask : fill

	// ***********************************************
	// five loads: fast and slow partner, bad signature last
	// ***********************************************
	initial begin
		fill(0);
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		for (int rnd = 0; rnd < 5; rnd++) begin
			if (rnd > 0) begin
				fill(rnd);
				slow <= rnd[0];
				axi_wr(eecl_pkg::CTRL_ADDR, 32'h0000_0001, rs);
			end
			axi_rd(eecl_pkg::STAT_ADDR, d, rs);
			check(d, {30'h0000_0000, good, 1'b1});
			check({30'h0000_0000, sig, done}, {30'h0000_0000, good, 1'b1});
			for (int p = 0; p < 4; p++)
				for (int k = 0; k < 10; k++) begin
					axi_rd({2'h0, p[1:0], OFFS[k]}, d, rs);
					check(d, exp_cfg(p, OFFS[k]));
				end
			// loaded fields ignore host writes; unmapped places answer with an error
			axi_wr(12'h0EC, {lfsr(), lfsr()}, rs);
			check(32'(rs), 32'(eecl_pkg::RESP_OKAY));
			axi_rd(12'h0EC, d, rs);
			check(d, exp_cfg(0, 8'hEC));
			axi_rd(12'h800, d, rs);
			check(32'(rs), 32'(eecl_pkg::RESP_SLVERR));
			axi_wr(12'hC04, 32'h0000_0001, rs);
			check(32'(rs), 32'(eecl_pkg::RESP_SLVERR));
		end
		give_verdict();
	end

	// a hung handshake ends the run; the five loads need around a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule : eeprom_config_preload_map_test

bind eecl_loader eecl_properties prop_u (.CLK(CLK), .RESET(RESET), .EE_REQ(EE_REQ),
	.EE_ADDR(EE_ADDR), .EE_VALID(EE_VALID), .LOAD_DONE(LOAD_DONE), .SIG_OK(SIG_OK),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RRESP(S_AXI_RRESP));
`default_nettype wire
